// ==== design/rgp_port.sv ====
// phy-side reduced gigabit port: transmit sampler and receive driver
//
// Behaviour
// - PHY drives rx clock per speed
// - rx control rising edge carries valid
// - rx control falling edge carries valid/error combination
// - rx nibble aligned to rx rising edge
`timescale 1ns/100ps
module rgp_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // link speed: high selects 100 Mb/s
    input wire logic speed_100_i,
    // transmit pins from the mac
    input wire logic tx_clk_i,
    input wire logic tx_ctl_i,
    input wire logic [3:0] tx_data_i,
    // decoded transmit stream
    output logic tx_en_o,
    output logic tx_err_o,
    output logic [3:0] tx_nib_o,
    output logic tx_stb_o,
    // receive stream from the line side
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic rx_dv_i,
    input wire logic rx_er_i,
    input wire logic [3:0] rx_nib_i,
    // receive pins to the mac
    output logic rx_clk_o,
    output logic rx_ctl_o,
    output logic [3:0] rx_data_o
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] tclk_s;
        logic [1:0] tctl_s0;
        logic [3:0] td_s0;
        logic [3:0] td_s1;
        logic rise_ctl;
        logic [3:0] rise_nib;
        logic tx_en;
        logic tx_err;
        logic [3:0] tx_nib;
        logic tx_stb;
        rgp_pkg::rgp_rx_state_t st;
        logic [7:0] half_cnt;
        logic [5:0] word;
        logic word_ok;
        logic rclk;
        logic rctl;
        logic [3:0] rdat;
    } rgp_state_t;

    rgp_state_t s_r;
    rgp_state_t s_nxt;

    logic [5:0] fifo_word;
    logic fifo_valid;
    logic fifo_take;
    logic [7:0] half_len;

    // fifo between line side stream and receive pins
    rgp_fifo #(
        .WIDTH(rgp_pkg::WORD_W),
        .DEPTH(rgp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .in_data_i({rx_dv_i, rx_er_i, rx_nib_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_take),
        .out_data_o(fifo_word)
    );

    // 20 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s
    assign half_len = speed_100_i ? 8'(rgp_pkg::HALF_100_CYC) : 8'(rgp_pkg::HALF_10_CYC);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        fifo_take = 1'b0;
        s_nxt.tx_stb = 1'b0;
        // two-flop sync of transmit pins; third tap feeds edge detect only
        s_nxt.tclk_s = {s_r.tclk_s[1:0], tx_clk_i};
        s_nxt.tctl_s0 = {s_r.tctl_s0[0], tx_ctl_i};
        s_nxt.td_s0 = tx_data_i;
        s_nxt.td_s1 = s_r.td_s0;
        // rising edge of tx clock: capture enable and nibble
        if (s_r.tclk_s[1] && !s_r.tclk_s[2]) begin
            s_nxt.rise_ctl = s_r.tctl_s0[1];
            s_nxt.rise_nib = s_r.td_s1;
        end
        // falling edge: recover error as xor of both halves
        if (!s_r.tclk_s[1] && s_r.tclk_s[2]) begin
            s_nxt.tx_en = s_r.rise_ctl;
            s_nxt.tx_err = s_r.rise_ctl ^ s_r.tctl_s0[1];
            s_nxt.tx_nib = s_r.rise_nib;
            s_nxt.tx_stb = 1'b1;
        end
        // receive clock generator and pin driver
        case (s_r.st)
            rgp_pkg::RGP_RX_IDLE: begin
                s_nxt.half_cnt = rgp_pkg::HALF_CNT_RST;
                s_nxt.st = rgp_pkg::RGP_RX_RISE;
            end
            rgp_pkg::RGP_RX_RISE: begin
                if (s_r.half_cnt + 8'h01 >= half_len) begin
                    // start high phase: new nibble and valid
                    fifo_take = 1'b1;
                    s_nxt.word = fifo_valid ? fifo_word : rgp_pkg::WORD_RST;
                    s_nxt.rclk = 1'b1;
                    s_nxt.rctl = fifo_valid & fifo_word[5];
                    s_nxt.rdat = fifo_valid ? fifo_word[3:0] : 4'h0;
                    s_nxt.word_ok = fifo_valid;
                    s_nxt.half_cnt = rgp_pkg::HALF_CNT_RST;
                    s_nxt.st = rgp_pkg::RGP_RX_FALL;
                end else begin
                    s_nxt.half_cnt = s_r.half_cnt + 8'h01;
                end
            end
            rgp_pkg::RGP_RX_FALL: begin
                if (s_r.half_cnt + 8'h01 >= half_len) begin
                    s_nxt.rclk = 1'b0;
                    s_nxt.rctl = s_r.word_ok & (s_r.word[5] ^ s_r.word[4]);
                    s_nxt.half_cnt = rgp_pkg::HALF_CNT_RST;
                    s_nxt.st = rgp_pkg::RGP_RX_RISE;
                end else begin
                    s_nxt.half_cnt = s_r.half_cnt + 8'h01;
                end
            end
            default: begin
                s_nxt.st = rgp_pkg::RGP_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '{st: rgp_pkg::RGP_RX_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_en_o = s_r.tx_en;
    assign tx_err_o = s_r.tx_err;
    assign tx_nib_o = s_r.tx_nib;
    assign tx_stb_o = s_r.tx_stb;
    assign rx_clk_o = s_r.rclk;
    assign rx_ctl_o = s_r.rctl;
    assign rx_data_o = s_r.rdat;

    ////////////////////////////////////////////////////////////////////////
    a_rx_rise_valid: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(rx_clk_o) |-> rx_ctl_o == (s_r.word_ok & s_r.word[5]))
        else $error("rx control at rising edge is not valid");
    a_rx_fall_xor: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(rx_clk_o) |-> rx_ctl_o == (s_r.word_ok & (s_r.word[5] ^ s_r.word[4])))
        else $error("rx control at falling edge is not xor");
    a_rx_nib_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$rose(rx_clk_o) |-> $stable(rx_data_o))
        else $error("rx nibble changed away from rising edge");
    a_rx_clk_fast: assert property (@(posedge clk_i) disable iff (!resetn_i)
        speed_100_i && $rose(rx_clk_o) ##1 speed_100_i |-> !rx_clk_o)
        else $error("rx clock high phase too long at 100 Mb/s");
    a_rx_clk_slow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!speed_100_i [*8]) ##0 $rose(rx_clk_o) |-> rx_clk_o [*8])
        else $error("rx clock high phase too short at 10 Mb/s");
    a_tx_err_xor: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_stb_o |-> tx_err_o == (tx_en_o ^ $past(s_r.tctl_s0[1])))
        else $error("tx error not xor of control halves");
    a_tx_en_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_stb_o |-> tx_en_o == $past(s_r.rise_ctl))
        else $error("tx enable not taken from rising half");
    a_tx_nib_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_stb_o |-> tx_nib_o == $past(s_r.rise_nib))
        else $error("tx nibble not taken from rising edge");

    // phase timing, idle fill and capture points
    a_rx_fast_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
        speed_100_i && $fell(rx_clk_o) ##1 speed_100_i |-> rx_clk_o)
        else $error("rx clock low phase too long at 100 Mb/s");
    a_rx_slow_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!speed_100_i [*8]) ##0 $fell(rx_clk_o) |-> (!rx_clk_o) [*8])
        else $error("rx clock low phase too short at 10 Mb/s");
    a_rx_half_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_r.half_cnt < 8'(rgp_pkg::HALF_10_CYC))
        else $error("rx half period counter ran past its limit");
    a_rx_ctl_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rx_clk_o && !$rose(rx_clk_o) |-> $stable(rx_ctl_o))
        else $error("rx control changed inside high phase");
    a_rx_ctl_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !rx_clk_o && !$fell(rx_clk_o) |-> $stable(rx_ctl_o))
        else $error("rx control changed inside low phase");
    a_rx_idle_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(rx_clk_o) && !$past(fifo_valid) |-> !rx_ctl_o && (rx_data_o == 4'h0))
        else $error("rx pins not idle with empty fifo");
    a_rx_rise_fifo: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(rx_clk_o) |-> rx_ctl_o == ($past(fifo_valid) & $past(fifo_word[5])))
        else $error("rx valid not taken from fifo word");
    a_rx_nib_fifo: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(rx_clk_o) |-> rx_data_o == ($past(fifo_valid) ? $past(fifo_word[3:0]) : 4'h0))
        else $error("rx nibble not taken from fifo word");
    a_tx_stb_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_stb_o |=> !tx_stb_o)
        else $error("tx strobe longer than one cycle");
    a_tx_stb_fall: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_stb_o |-> $past(s_r.tclk_s[2]) && !$past(s_r.tclk_s[1]))
        else $error("tx strobe without falling tx clock");
    a_tx_rise_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(s_r.tclk_s[2]) |-> s_r.rise_ctl == $past(s_r.tctl_s0[1]))
        else $error("tx enable not captured at rising tx clock");
endmodule // rgp_port

// ==== design/rgp_pkg.sv ====
// shared constants for the phy-side reduced gigabit port
package rgp_pkg;
    // system clock period and link half periods in ns
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned LINK_HALF_100_NS = 20;
    localparam int unsigned LINK_HALF_10_NS = 200;
    // half periods of the receive clock in system cycles, rounded down, at least one
    localparam int unsigned HALF_100_CYC = (LINK_HALF_100_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (LINK_HALF_100_NS / CLK_PERIOD_NS);
    localparam int unsigned HALF_10_CYC = LINK_HALF_10_NS / CLK_PERIOD_NS;
    localparam int unsigned HALF_CNT_W = 8;
    localparam logic [7:0] HALF_CNT_RST = 8'h00;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned WORD_W = 6;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned SYNC_LEN = 2;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [5:0] WORD_RST = 6'h00;
    typedef enum logic [1:0] {
        RGP_RX_IDLE = 2'b00,
        RGP_RX_RISE = 2'b01,
        RGP_RX_FALL = 2'b11
    } rgp_rx_state_t;
endpackage

// ==== design/rgp_fifo.sv ====
// parameterised valid/ready fifo with registered read data
`timescale 1ns/100ps
module rgp_fifo #(
    parameter int unsigned WIDTH = 6,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [WIDTH-1:0] dout;
        logic dv;
        logic rdy;
    } rgp_fifo_state_t;

    rgp_fifo_state_t s_r;
    rgp_fifo_state_t s_nxt;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // ready is registered from the next pointers, so it always equals not-full
    assign full = !s_r.rdy;
    assign empty = (s_r.wp == s_r.rp);
    assign push = in_valid_i && s_r.rdy;
    // load output register when it is empty or being taken
    assign pop = !empty && (!s_r.dv || out_ready_i);
    assign in_ready_o = s_r.rdy;
    assign out_valid_o = s_r.dv;
    assign out_data_o = s_r.dout;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
            s_nxt.wp = s_r.wp + (AW+1)'(1);
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + (AW+1)'(1);
            s_nxt.dout = s_r.mem[s_r.rp[AW-1:0]];
            s_nxt.dv = 1'b1;
        end else if (out_ready_i) begin
            s_nxt.dv = 1'b0;
        end
        // full once the write pointer has lapped the read pointer
        s_nxt.rdy = !((s_nxt.wp[AW] != s_nxt.rp[AW]) && (s_nxt.wp[AW-1:0] == s_nxt.rp[AW-1:0]));
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '{rdy: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    a_fifo_no_over: assert property (@(posedge clk_i) disable iff (!resetn_i)
        full |-> ##1 (s_r.wp == $past(s_r.wp)))
        else $error("fifo write pointer moved while full");
    a_fifo_no_under: assert property (@(posedge clk_i) disable iff (!resetn_i)
        empty && !s_r.dv |=> !s_r.dv)
        else $error("fifo produced data while empty");
    a_fifo_ready_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_r.rdy == !((s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0])))
        else $error("fifo ready does not match its pointers");
endmodule // rgp_fifo

// ==== verif/rgp_mac_model.sv ====
// mac-side model driving the transmit pins
`timescale 1ns/100ps
module rgp_mac_model (
    // transmit pins
    output logic tx_clk_o,
    output logic tx_ctl_o,
    output logic [3:0] tx_data_o
);
    initial begin
        tx_clk_o = 1'b0;
        tx_ctl_o = 1'b0;
        tx_data_o = 4'h0;
    end
    // one nibble per 200 ns clock; clock stands low between frames
    task automatic send(input logic en, input logic er, input logic [3:0] nib);
        tx_ctl_o = en;
        tx_data_o = nib;
        #50 tx_clk_o = 1'b1;
        #100 tx_clk_o = 1'b0;
        tx_ctl_o = en ^ er;
        tx_data_o = ~nib;
        #50;
    endtask
endmodule // rgp_mac_model

// ==== verif/rgmii_phy_side_port_tb.sv ====
// self-checking bench for the phy-side port
`timescale 1ns/100ps
module rgmii_phy_side_port_tb;
    logic clk_i = 1'b0, resetn_i = 1'b0, speed_100_i = 1'b1, rx_valid_i = 1'b0;
    logic rx_dv_i = 1'b0, rx_er_i = 1'b0, tx_clk, tx_ctl;
    logic [3:0] rx_nib_i = 4'h0, tx_data, tx_nib_o, rx_data_o;
    logic tx_en_o, tx_err_o, tx_stb_o, rx_ready_o, rx_clk_o, rx_ctl_o, prev_rx = 1'b0;
    logic seen_full = 1'b0;
    logic [7:0] w, fall_exp = 8'h00;
    int err_count = 0, samples_checked = 0, cyc = 0, seed = 39182, q[$], s[$], tq[$];
    always #12.5 clk_i = ~clk_i;
    rgp_mac_model mac (.tx_clk_o(tx_clk), .tx_ctl_o(tx_ctl), .tx_data_o(tx_data));
    rgp_port uut (.clk_i(clk_i), .resetn_i(resetn_i), .speed_100_i(speed_100_i),
        .tx_clk_i(tx_clk), .tx_ctl_i(tx_ctl), .tx_data_i(tx_data), .tx_en_o(tx_en_o),
        .tx_err_o(tx_err_o), .tx_nib_o(tx_nib_o), .tx_stb_o(tx_stb_o), .rx_valid_i(rx_valid_i),
        .rx_ready_o(rx_ready_o), .rx_dv_i(rx_dv_i), .rx_er_i(rx_er_i), .rx_nib_i(rx_nib_i),
        .rx_clk_o(rx_clk_o), .rx_ctl_o(rx_ctl_o), .rx_data_o(rx_data_o));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // reference model of both directions
    always @(posedge clk_i) begin
        cyc++;
        if (resetn_i && !rx_ready_o) seen_full = 1'b1;
        if (resetn_i && rx_valid_i && rx_ready_o) begin
            q.push_back({rx_dv_i, rx_er_i, rx_nib_i});
            s.push_back(cyc);
        end
        if (resetn_i && rx_clk_o && !prev_rx) begin
            w = 8'h00;
            if (q.size() > 0 && cyc - s[0] >= 3) begin
                w = q.pop_front();
                void'(s.pop_front());
            end
            check("rx_ctl rise", {7'h00, rx_ctl_o}, {7'h00, w[5]});
            check("rx_data", {4'h0, rx_data_o}, {4'h0, w[3:0]});
            fall_exp = {7'h00, w[5] ^ w[4]};
        end
        if (resetn_i && !rx_clk_o && prev_rx) check("rx_ctl fall", {7'h00, rx_ctl_o}, fall_exp);
        prev_rx = rx_clk_o;
        if (tx_stb_o === 1'b1) begin
            w = (tq.size() > 0) ? tq.pop_front() : 8'hff;
            check("tx word", {2'h0, tx_en_o, tx_err_o, tx_nib_o}, w);
        end
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic rx_burst(input int n, input logic always_valid);
        repeat (n) begin
            @(posedge clk_i);
            rx_valid_i <= always_valid | $random(seed);
            {rx_dv_i, rx_er_i, rx_nib_i} <= $random(seed);
        end
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        repeat (600) @(posedge clk_i);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        fork
            begin
                rx_burst(40, 1'b0);
                @(posedge clk_i);
                speed_100_i <= 1'b0;
                rx_burst(40, 1'b0);
                rx_burst(24, 1'b1);
                check("fifo refused", {7'h00, seen_full}, 8'h01);
            end
            begin
                #1007;
                repeat (2) begin
                    repeat (6) begin
                        w = $random(seed);
                        tq.push_back({2'h0, w[5], w[4], w[3:0]});
                        mac.send(w[5], w[4], w[3:0]);
                    end
                    #1000;
                end
            end
        join
        check("rx left", q.size(), 8'h00);
        check("tx left", tq.size(), 8'h00);
        report_and_stop();
    end
endmodule // rgmii_phy_side_port_tb
